// file: hw/tsr_regs.sv
// Purpose: switch tuning registers and the controls they drive
// Assumes: config space access with byte enables; preload port from serial loaders
// Notes:   preload and software write in one cycle: preload wins per bit
`timescale 1ns/1ps
module tsr_regs
  import tsr_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  port_upstream,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_rd,
  input  wire logic [7:0]            cfg_addr,
  input  wire logic [3:0]            cfg_be,
  input  wire logic [31:0]           cfg_wdata,
  output logic      [31:0]           cfg_rdata,
  output logic                       cfg_rd_ack,
  input  wire logic                  pl_wr,
  input  wire logic [7:0]            pl_addr,
  input  wire logic [31:0]           pl_wdata,
  input  wire logic [TSR_RPL_W-1:0]  builtin_replay,
  input  wire logic [TSR_ACK_W-1:0]  builtin_ack,
  output logic      [TSR_RPL_W-1:0]  replay_timeout,
  output logic      [TSR_ACK_W-1:0]  ack_latency,
  output logic                       vga_decode_en,
  output logic                       pm_cap_disable,
  output logic                       msi_cap_disable,
  output logic      [31:0]           test_ctrl,
  input  wire logic [TSR_LENW-1:0]   pkt_len,
  input  wire logic                  slow_to_fast,
  output logic                       store_forward,
  output logic      [TSR_LENW-1:0]   fwd_start,
  input  wire logic [TSR_NPORT-1:0]  arb_req,
  input  wire logic [TSR_NPORT-1:0]  arb_credit_ok,
  input  wire logic                  arb_pkt_done,
  output logic      [TSR_PW-1:0]     arb_port,
  output logic                       arb_valid,
  output logic                       arb_send,
  input  wire logic                  credit_update,
  output logic      [TSR_NTYPE-1:0]  credit_release
);
  logic [31:0]          test_control_one;
  logic [31:0]          timer_reg;
  logic [31:0]          mode_reg;
  logic [31:0]          be_mask;
  logic                 sw_test;
  logic                 sw_timer;
  logic                 sw_mode;
  logic                 pl_test;
  logic                 pl_timer;
  logic                 pl_mode;
  logic [31:0]          next_test;
  logic [31:0]          next_timer;
  logic [31:0]          next_mode;
  logic [31:0]          rd_mux;
  logic [1:0]           ct_code;
  logic [TSR_LENW-1:0]  mid;
  logic [TSR_LENW-1:0]  next_fwd;
  logic [TSR_NTYPE-1:0] type_ptr;

  // Byte enables widened to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[b*8 +: 8] = {8{cfg_be[b]}};
    end
  end

  // The mode register decodes only on the upstream port
  assign sw_test  = cfg_wr && cfg_addr == TSR_OFS_TEST;
  assign sw_timer = cfg_wr && cfg_addr == TSR_OFS_TIMER;
  assign sw_mode  = cfg_wr && cfg_addr == TSR_OFS_MODE && port_upstream;
  assign pl_test  = pl_wr && pl_addr == TSR_OFS_TEST;
  assign pl_timer = pl_wr && pl_addr == TSR_OFS_TIMER;
  assign pl_mode  = pl_wr && pl_addr == TSR_OFS_MODE && port_upstream;

  always_comb begin
    next_test = test_control_one;
    if (sw_test) begin
      next_test = (next_test & ~(be_mask & TSR_SW_TEST))
                  | (cfg_wdata & be_mask & TSR_SW_TEST);
    end
    if (pl_test) begin
      next_test = pl_wdata;
    end
  end

  always_comb begin
    next_timer = timer_reg;
    // Read-only bits and reserved bit 15 stay out of the software mask
    if (sw_timer) begin
      next_timer = (next_timer & ~(be_mask & TSR_SW_TIMER))
                   | (cfg_wdata & be_mask & TSR_SW_TIMER);
    end
    // Loaders may also seed the read-only capability and decode bits
    if (pl_timer) begin
      next_timer = (next_timer & ~TSR_PL_TIMER)
                   | (pl_wdata & TSR_PL_TIMER);
    end
  end

  always_comb begin
    next_mode = mode_reg;
    if (sw_mode) begin
      next_mode = (next_mode & ~(be_mask & TSR_SW_MODE))
                  | (cfg_wdata & be_mask & TSR_SW_MODE);
    end
    if (pl_mode) begin
      next_mode = (next_mode & ~TSR_PL_MODE)
                  | (pl_wdata & TSR_PL_MODE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      test_control_one <= TSR_RST_TEST;
    end else begin
      test_control_one <= next_test;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_reg <= TSR_RST_TIMER;
    end else begin
      timer_reg <= next_timer;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_reg <= TSR_RST_MODE;
    end else begin
      mode_reg <= next_mode;
    end
  end

  // Unmapped offsets read as zero; other blocks own them
  always_comb begin
    rd_mux = '0;
    unique case (cfg_addr)
      TSR_OFS_TEST:  rd_mux = test_control_one;
      TSR_OFS_TIMER: rd_mux = timer_reg;
      TSR_OFS_MODE:  rd_mux = port_upstream ? mode_reg : '0;
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_rdata  <= '0;
      cfg_rd_ack <= 1'b0;
    end else begin
      cfg_rd_ack <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rd_mux;
      end
    end
  end

  // Effective link timers; a one-cycle lag keeps them glitch free
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      replay_timeout <= '0;
      ack_latency    <= '0;
    end else begin
      replay_timeout <= timer_reg[TSR_RPL_EN]
                        ? timer_reg[TSR_RPL_LSB +: TSR_RPL_W]
                        : builtin_replay;
      ack_latency    <= timer_reg[TSR_ACK_EN]
                        ? timer_reg[TSR_ACK_LSB +: TSR_ACK_W]
                        : builtin_ack;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vga_decode_en   <= 1'b1;
      pm_cap_disable  <= 1'b0;
      msi_cap_disable <= 1'b0;
      test_ctrl       <= TSR_RST_TEST;
    end else begin
      vga_decode_en   <= timer_reg[TSR_VGA];
      pm_cap_disable  <= timer_reg[TSR_PMDIS];
      msi_cap_disable <= timer_reg[TSR_MSIDIS];
      test_ctrl       <= test_control_one;
    end
  end

  // Forwarding start point in cycles of the received packet
  assign ct_code = mode_reg[TSR_CT_LSB +: 2];
  assign mid     = pkt_len >> 1;

  always_comb begin
    next_fwd = mid;
    if (mode_reg[TSR_SF]) begin
      next_fwd = pkt_len;
    end else if (slow_to_fast) begin
      // Clamp at zero so short packets never wrap
      next_fwd = (mid > TSR_LENW'(ct_code))
                 ? mid - TSR_LENW'(ct_code) : '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      store_forward <= 1'b0;
      fwd_start     <= '0;
    end else begin
      store_forward <= mode_reg[TSR_SF];
      fwd_start     <= next_fwd;
    end
  end

  tsr_rr_arb u_arb (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .sticky    (mode_reg[TSR_ARB]),
    .req       (arb_req),
    .credit_ok (arb_credit_ok),
    .pkt_done  (arb_pkt_done),
    .gnt_port  (arb_port),
    .gnt_valid (arb_valid),
    .gnt_send  (arb_send)
  );

  // Type-oriented mode walks posted, non-posted, completion in turn
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      type_ptr <= TSR_NTYPE'(1);
    end else if (credit_update && !mode_reg[TSR_CRD]) begin
      type_ptr <= {type_ptr[TSR_NTYPE-2:0], type_ptr[TSR_NTYPE-1]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      credit_release <= '0;
    end else if (credit_update) begin
      credit_release <= mode_reg[TSR_CRD] ? {TSR_NTYPE{1'b1}} : type_ptr;
    end else begin
      credit_release <= '0;
    end
  end
endmodule // tsr_regs

// file: hw/tsr_pkg.sv
// Purpose: constants for the switch tuning register bank
// Assumes: config space offsets are byte addresses, one dword each
// Notes:   field positions and reset values live here; the bench and checker repeat some as literals
package tsr_pkg;
  localparam logic [7:0]  TSR_OFS_TEST  = 8'h6C;
  localparam logic [7:0]  TSR_OFS_TIMER = 8'h70;
  localparam logic [7:0]  TSR_OFS_MODE  = 8'h74;
  localparam logic [31:0] TSR_RST_TEST  = 32'h04000800;
  localparam logic [31:0] TSR_RST_TIMER = 32'h80000000;
  localparam logic [31:0] TSR_RST_MODE  = 32'h00000102;
  localparam logic [31:0] TSR_SW_TEST   = 32'hFFFFFFFF;
  localparam logic [31:0] TSR_SW_TIMER  = 32'h7FFF1FFF;
  localparam logic [31:0] TSR_PL_TIMER  = 32'hFFFF7FFF;
  localparam logic [31:0] TSR_SW_MODE   = 32'h00003F7F;
  localparam logic [31:0] TSR_PL_MODE   = 32'h0000FFFF;
  localparam int          TSR_RPL_LSB   = 0;
  localparam int          TSR_RPL_W     = 12;
  localparam int          TSR_RPL_EN    = 12;
  localparam int          TSR_PMDIS     = 13;
  localparam int          TSR_MSIDIS    = 14;
  localparam int          TSR_ACK_LSB   = 16;
  localparam int          TSR_ACK_W     = 14;
  localparam int          TSR_ACK_EN    = 30;
  localparam int          TSR_VGA       = 31;
  localparam int          TSR_SF        = 0;
  localparam int          TSR_CT_LSB    = 1;
  localparam int          TSR_ARB       = 3;
  localparam int          TSR_CRD       = 4;
  localparam int          TSR_NPORT     = 6;
  localparam int          TSR_PW        = 3;
  localparam int          TSR_LENW      = 10;
  localparam int          TSR_NTYPE     = 3;
endpackage

// file: hw/tsr_rr_arb.sv
// Purpose: round-robin port arbiter with selectable credit policy
// Assumes: req and credit_ok are per-port levels; pkt_done ends a grant
// Notes:   sticky mode can stall on a port that lacks credit
`timescale 1ns/1ps
module tsr_rr_arb
  import tsr_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 sticky,
  input  wire logic [TSR_NPORT-1:0] req,
  input  wire logic [TSR_NPORT-1:0] credit_ok,
  input  wire logic                 pkt_done,
  output logic      [TSR_PW-1:0]    gnt_port,
  output logic                      gnt_valid,
  output logic                      gnt_send
);
  logic [TSR_PW-1:0] next_port;
  logic              next_valid;
  logic              found;
  logic [TSR_PW-1:0] cand;
  logic              hold;

  always_comb begin
    found = 1'b0;
    cand  = gnt_port;
    for (int k = 1; k <= TSR_NPORT; k++) begin
      if (!found) begin
        cand = TSR_PW'((int'(gnt_port) + k) % TSR_NPORT);
        if (req[cand] && credit_ok[cand]) begin
          found = 1'b1;
        end
      end
    end
  end

  always_comb begin
    // Sticky keeps a pending port whatever its credit
    hold = gnt_valid && req[gnt_port] && !pkt_done
           && (sticky || credit_ok[gnt_port]);
    next_port  = gnt_port;
    next_valid = 1'b0;
    if (hold) begin
      next_valid = 1'b1;
    end else if (found) begin
      next_port  = cand;
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gnt_port  <= '0;
      gnt_valid <= 1'b0;
    end else begin
      gnt_port  <= next_port;
      gnt_valid <= next_valid;
    end
  end

  // Data only moves when the granted port also has credit
  assign gnt_send = gnt_valid && credit_ok[gnt_port];
endmodule // tsr_rr_arb

// file: tb/tsr_regs_checker.sv
// Purpose: port-level checks for the tuning register bank
// Assumes: one clock domain, synchronous active-high reset
// Notes:   register state is hidden, so checks tie outputs to port causes
`timescale 1ns/1ps
module tsr_regs_checker
  import tsr_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 port_upstream,
  input wire logic                 cfg_rd,
  input wire logic [7:0]           cfg_addr,
  input wire logic [31:0]          cfg_rdata,
  input wire logic                 cfg_rd_ack,
  input wire logic                 pl_wr,
  input wire logic                 vga_decode_en,
  input wire logic [31:0]          test_ctrl,
  input wire logic [TSR_LENW-1:0]  pkt_len,
  input wire logic                 slow_to_fast,
  input wire logic                 store_forward,
  input wire logic [TSR_LENW-1:0]  fwd_start,
  input wire logic [TSR_NPORT-1:0] arb_req,
  input wire logic [TSR_NPORT-1:0] arb_credit_ok,
  input wire logic [TSR_PW-1:0]    arb_port,
  input wire logic                 arb_valid,
  input wire logic                 arb_send,
  input wire logic                 credit_update,
  input wire logic [TSR_NTYPE-1:0] credit_release
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [TSR_NPORT-1:0] prev_ok;
  // Ports that asked with credit at the edge a new grant was decided
  always_ff @(posedge clk_sys) begin
    prev_ok <= arb_req & arb_credit_ok;
  end
  property p_rd_ack; cfg_rd |=> cfg_rd_ack; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not acknowledged");
  property p_test_rst; $fell(rst) |-> test_ctrl == 32'h04000800; endproperty
  a_test_rst: assert property (p_test_rst) else $error("test control reset");
  // Only the loader may clear it; allow either register lag
  property p_vga_ro; $fell(vga_decode_en) |-> $past(pl_wr) || $past(pl_wr, 2); endproperty
  a_vga_ro: assert property (p_vga_ro) else $error("decode enable changed");
  property p_down_rd; cfg_rd && cfg_addr == 8'h74 && !port_upstream |=> cfg_rdata == 32'h0;
  endproperty
  a_down_rd: assert property (p_down_rd) else $error("mode seen downstream");
  property p_sf; store_forward [*3] |-> fwd_start == $past(pkt_len); endproperty
  a_sf: assert property (p_sf) else $error("store-forward start");
  property p_ct_mid; (!store_forward && !slow_to_fast) [*3] |-> fwd_start == ($past(pkt_len) >> 1);
  endproperty
  a_ct_mid: assert property (p_ct_mid) else $error("cut-through start");
  property p_arb_idle; arb_req == 6'h00 |=> !arb_valid; endproperty
  a_arb_idle: assert property (p_arb_idle) else $error("grant without request");
  property p_arb_send; arb_valid |-> arb_send == arb_credit_ok[arb_port]; endproperty
  a_arb_send: assert property (p_arb_send) else $error("send without credit");
  property p_arb_new;
    arb_valid && (!$past(arb_valid) || arb_port != $past(arb_port)) |-> prev_ok[arb_port];
  endproperty
  a_arb_new: assert property (p_arb_new) else $error("new grant without credit");
  property p_crd; credit_update |=> credit_release == 3'h7 || $onehot(credit_release); endproperty
  a_crd: assert property (p_crd) else $error("credit release shape");
  property p_crd_idle; !credit_update |=> credit_release == 3'h0; endproperty
  a_crd_idle: assert property (p_crd_idle) else $error("credit released idle");
  c_read: cover property (cfg_rd_ack);
  c_grant: cover property (arb_valid && !arb_send);
  c_all: cover property (credit_release == 3'h7);
endmodule // tsr_regs_checker
bind tsr_regs tsr_regs_checker tsr_regs_checker_inst (.clk_sys, .rst, .port_upstream,
  .cfg_rd, .cfg_addr, .cfg_rdata, .cfg_rd_ack, .pl_wr, .vga_decode_en, .test_ctrl, .pkt_len,
  .slow_to_fast, .store_forward, .fwd_start, .arb_req, .arb_credit_ok, .arb_port, .arb_valid,
  .arb_send, .credit_update, .credit_release);

// file: tb/tsr_regs_tb_top.sv
// Purpose: self-checking bench for the tuning register bank
// Assumes: drives land 1 ns after the rising edge
// Notes:   a shadow of each register predicts every read
`timescale 1ns/1ps
module tsr_regs_tb_top
  import tsr_pkg::*;
;
  logic                 clk_sys, rst, port_upstream, cfg_wr, cfg_rd, pl_wr, cfg_rd_ack;
  logic                 slow_to_fast, arb_pkt_done, credit_update, store_forward;
  logic                 arb_valid, arb_send, vga_decode_en, pm_cap_disable, msi_cap_disable;
  logic [7:0]           cfg_addr, pl_addr, a;
  logic [3:0]           cfg_be;
  logic [31:0]          cfg_wdata, cfg_rdata, pl_wdata, test_ctrl, m_test, m_timer, m_mode;
  logic [11:0]          builtin_replay, replay_timeout;
  logic [13:0]          builtin_ack, ack_latency;
  logic [9:0]           pkt_len, fwd_start;
  logic [5:0]           arb_req, arb_credit_ok;
  logic [2:0]           arb_port, credit_release;
  int                   errors, total_checks, n;
  logic [7:0]           ofs [4] = '{8'h6C, 8'h70, 8'h74, 8'h78};
  tsr_regs tsr_regs_inst (.clk_sys, .rst, .port_upstream, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_rd_ack, .pl_wr, .pl_addr, .pl_wdata, .builtin_replay,
    .builtin_ack, .replay_timeout, .ack_latency, .vga_decode_en, .pm_cap_disable,
    .msi_cap_disable, .test_ctrl, .pkt_len, .slow_to_fast, .store_forward, .fwd_start,
    .arb_req, .arb_credit_ok, .arb_pkt_done, .arb_port, .arb_valid, .arb_send,
    .credit_update, .credit_release);
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] merge(input logic [31:0] o, d, m, input logic [3:0] be);
    logic [31:0] k;
    k = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
    return (o & ~k) | (d & k);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] ad);
    case (ad)
      8'h6C: return m_test;
      8'h70: return m_timer;
      8'h74: return port_upstream ? m_mode : 32'h0;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [9:0] exp_fwd;
    logic [9:0] h;
    h = pkt_len >> 1;
    if (m_mode[0]) return pkt_len;
    if (!slow_to_fast) return h;
    return (h > m_mode[2:1]) ? h - m_mode[2:1] : 10'h0;
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
    tick(1);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, ad, be, d};
    tick(1);
    cfg_wr = 0;
    if (ad == 8'h6C) m_test = merge(m_test, d, TSR_SW_TEST, be);
    if (ad == 8'h70) m_timer = merge(m_timer, d, TSR_SW_TIMER, be);
    if (ad == 8'h74 && port_upstream) m_mode = merge(m_mode, d, TSR_SW_MODE, be);
  endtask
  task automatic rd_chk(input logic [7:0] ad);
    tick(1);
    {cfg_rd, cfg_addr} = {1'b1, ad};
    tick(1);
    cfg_rd = 0;
    n = 0;
    while (cfg_rd_ack !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    if (n == 4) begin
      errors++;
      wrap_up();
    end
    check("cfg_rdata", cfg_rdata, exp_rd(ad));
  endtask
  task automatic pulse_credit(input logic [2:0] exp);
    tick(1);
    credit_update = 1;
    tick(1);
    credit_update = 0;
    check("credit_release", credit_release, exp);
  endtask
  initial begin
    {rst, port_upstream} = 2'b11;
    {cfg_wr, cfg_rd, pl_wr, slow_to_fast, arb_pkt_done, credit_update} = '0;
    {cfg_addr, pl_addr, cfg_be, cfg_wdata, pl_wdata, arb_req, arb_credit_ok} = '0;
    void'($urandom(58));
    {builtin_replay, builtin_ack, pkt_len} = {$urandom, 4'h0};
    {m_test, m_timer, m_mode} = {32'h04000800, 32'h80000000, 32'h00000102};
    tick(8);
    rst = 0;
    tick(2);
    check("replay_timeout", replay_timeout, builtin_replay);
    for (int i = 0; i < 4; i++) rd_chk(ofs[i]);
    for (int i = 0; i < 24; i++) begin
      a = ofs[$urandom_range(3, 0)];
      wr(a, 4'($urandom), $urandom);
      rd_chk(a);
    end
    wr(8'h70, 4'hF, $urandom | 32'h40001000);
    tick(1);
    check("replay_timeout", replay_timeout, m_timer[11:0]);
    check("ack_latency", ack_latency, m_timer[29:16]);
    wr(8'h70, 4'hF, $urandom & 32'hBFFFEFFF);
    tick(1);
    check("ack_latency", ack_latency, builtin_ack);
    {pl_wr, pl_addr, pl_wdata} = {1'b1, 8'h70, $urandom & 32'h7FFFFFFF};
    tick(1);
    pl_wr = 0;
    m_timer = (m_timer & ~TSR_PL_TIMER) | (pl_wdata & TSR_PL_TIMER);
    tick(1);
    check("vga_decode_en", vga_decode_en, m_timer[31]);
    check("pm_cap_disable", pm_cap_disable, m_timer[13]);
    check("msi_cap_disable", msi_cap_disable, m_timer[14]);
    rd_chk(8'h70);
    for (int i = 0; i < 16; i++) begin
      // Short packet with the largest code must clamp at zero
      {slow_to_fast, pkt_len} = {i[3], (i == 14) ? 10'h004 : 10'($urandom)};
      wr(8'h74, 4'h1, ($urandom & 32'hF8) | i[2:0]);
      tick(1);
      check("store_forward", store_forward, m_mode[0]);
      check("fwd_start", fwd_start, exp_fwd());
    end
    wr(8'h74, 4'hF, 32'h0);
    for (int i = 0; i < 4; i++) pulse_credit(3'h1 << (i % 3));
    wr(8'h74, 4'hF, 32'h10);
    pulse_credit(3'h7);
    {arb_req, arb_credit_ok} = 12'h104;
    tick(3);
    check("arb_port", {arb_valid, arb_port}, 4'hA);
    arb_credit_ok = 6'h00;
    tick(3);
    check("arb_valid", arb_valid, 1'b0);
    wr(8'h74, 4'hF, 32'h08);
    arb_credit_ok = 6'h04;
    tick(3);
    arb_credit_ok = 6'h00;
    tick(3);
    check("arb_hold", {arb_valid, arb_send, arb_port}, 5'h12);
    {arb_req, arb_credit_ok, arb_pkt_done} = 13'h0929;
    tick(1);
    arb_pkt_done = 0;
    check("arb_port", {arb_valid, arb_port}, 4'hC);
    port_upstream = 0;
    wr(8'h74, 4'hF, $urandom);
    rd_chk(8'h74);
    port_upstream = 1;
    rd_chk(8'h74);
    check("test_ctrl", test_ctrl, m_test);
    wrap_up();
  end
endmodule // tsr_regs_tb_top
